// File: shared/bbx_defs.svh
`ifndef BBX_DEFS_SVH
`define BBX_DEFS_SVH

// Widths
`define BBX_PC_W        16
`define BBX_OFF_W       12

// Status flag positions
`define BBX_FLG_C       0
`define BBX_FLG_Z       1
`define BBX_FLG_N       2
`define BBX_FLG_V       3
`define BBX_FLG_S       4
`define BBX_FLG_H       5
`define BBX_FLG_T       6
`define BBX_FLG_I       7
`define BBX_FLAGS_RST   8'h00

// Cycle counts per instruction class
`define BBX_CYC_ONE     3'h1
`define BBX_CYC_JMP_REL 3'h2
`define BBX_CYC_JMP_Z   3'h2
`define BBX_CYC_JMP_ABS 3'h3
`define BBX_CYC_CAL_REL 3'h3
`define BBX_CYC_CAL_Z   3'h3
`define BBX_CYC_CAL_ABS 3'h4
`define BBX_CYC_RET     3'h4
`define BBX_CYC_SKIP1   3'h2
`define BBX_CYC_SKIP2   3'h3
`define BBX_CYC_BR_TAKE 3'h2
`define BBX_CYC_IO_BIT  3'h2
`define BBX_CYC_RUN_ADJ 3'h2

// Program counter steps
`define BBX_STEP_ONE    1
`define BBX_STEP_TWO    2
`define BBX_STEP_THREE  3

`endif

// File: shared/bbx_pkg.sv
`include "bbx_defs.svh"

package bbx_pkg;

	typedef enum logic [4:0] {
		BBX_OP_NONE, BBX_OP_JMP_REL, BBX_OP_JMP_Z, BBX_OP_JMP_ABS,
		BBX_OP_CAL_REL, BBX_OP_CAL_Z, BBX_OP_CAL_ABS, BBX_OP_RET,
		BBX_OP_INTERRUPT_EXIT, BBX_OP_COMPARE_SKIP_EQUAL, BBX_OP_CMP, BBX_OP_CMPC, BBX_OP_CPI,
		BBX_OP_SK_RBC, BBX_OP_SK_RBS, BBX_OP_SK_IOC, BBX_OP_SK_IOS,
		BBX_OP_BR_SET, BBX_OP_BR_CLR, BBX_OP_BR_GE, BBX_OP_BR_LT,
		BBX_OP_IO_SET, BBX_OP_IO_CLR, BBX_OP_ROL, BBX_OP_ROR,
		BBX_OP_ASR, BBX_OP_LSL, BBX_OP_LSR, BBX_OP_BST, BBX_OP_BLD,
		BBX_OP_FLG_SET, BBX_OP_FLG_CLR
	} bbx_op_t;

	typedef enum logic [1:0] {
		BBX_ST_IDLE = 2'b01,
		BBX_ST_RUN  = 2'b10
	} bbx_state_t;

	typedef struct packed {
		bbx_state_t             st;
		logic [1:0]             cnt;
		logic                   ready;
		logic                   done;
		logic                   pc_wr;
		logic                   p_pc_wr;
		logic                   p_ret;
		logic                   p_interrupt_exit;
		logic [`BBX_PC_W-1:0]   pc_new;
		logic                   push;
		logic                   p_push;
		logic [`BBX_PC_W-1:0]   push_data;
		logic                   pop;
		logic                   io_wr;
		logic                   p_io_wr;
		logic [7:0]             io_wdata;
		logic                   reg_wr;
		logic                   p_reg_wr;
		logic [7:0]             reg_wdata;
		logic [7:0]             flags;
		logic [7:0]             p_flags;
	} bbx_regs_t;

endpackage : bbx_pkg

// File: verilog/bbx_cond.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbx_defs.svh"

module bbx_cond
	import bbx_pkg::*;
(
	// Decode
	input  wire bbx_op_t    op,
	input  wire logic [2:0] bit_sel,
	input  wire logic [2:0] flag_sel,
	// Operands
	input  wire logic [7:0] rd_val,
	input  wire logic [7:0] rr_val,
	input  wire logic [7:0] io_rdata,
	input  wire logic [7:0] flags,
	// Result
	output var  logic       take
);

	logic sgn;

	always_comb begin
		sgn = flags[`BBX_FLG_N] ^ flags[`BBX_FLG_V];
		case (op)
			BBX_OP_COMPARE_SKIP_EQUAL:   take = (rd_val == rr_val);
			BBX_OP_SK_RBC: take = ~rd_val[bit_sel];
			BBX_OP_SK_RBS: take = rd_val[bit_sel];
			BBX_OP_SK_IOC: take = ~io_rdata[bit_sel];
			BBX_OP_SK_IOS: take = io_rdata[bit_sel];
			BBX_OP_BR_SET: take = flags[flag_sel];
			BBX_OP_BR_CLR: take = ~flags[flag_sel];
			BBX_OP_BR_GE:  take = ~sgn;
			BBX_OP_BR_LT:  take = sgn;
			default:       take = 1'b0;
		endcase
	end

endmodule : bbx_cond
`default_nettype wire

// File: verilog/bbx_shift.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbx_defs.svh"

module bbx_shift
	import bbx_pkg::*;
(
	// Decode
	input  wire bbx_op_t    op,
	// Operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic [7:0] flags_in,
	// Result
	output var  logic [7:0] res,
	output var  logic [7:0] flags_out
);

	logic c_in;
	logic c_out;
	logic n;
	logic v;

	always_comb begin
		c_in      = flags_in[`BBX_FLG_C];
		flags_out = flags_in;
		res       = a;
		c_out     = c_in;
		case (op)
			BBX_OP_CMP, BBX_OP_CMPC, BBX_OP_CPI: begin
				// Subtract only for flags; carry used by the chained form
				res = a - b - ((op == BBX_OP_CMPC) ? {7'h00, c_in} : 8'h00);
				c_out = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
				flags_out[`BBX_FLG_H] = (~a[3] & b[3]) | (b[3] & res[3])
					| (res[3] & ~a[3]);
				flags_out[`BBX_FLG_V] = (a[7] & ~b[7] & ~res[7])
					| (~a[7] & b[7] & res[7]);
			end
			BBX_OP_ROL: begin
				res   = {a[6:0], c_in};
				c_out = a[7];
			end
			BBX_OP_ROR: begin
				res   = {c_in, a[7:1]};
				c_out = a[0];
			end
			BBX_OP_ASR: begin
				res   = {a[7], a[7:1]};
				c_out = a[0];
			end
			BBX_OP_LSL: begin
				res   = {a[6:0], 1'b0};
				c_out = a[7];
			end
			BBX_OP_LSR: begin
				res   = {1'b0, a[7:1]};
				c_out = a[0];
			end
			default: begin
				res   = a;
				c_out = c_in;
			end
		endcase
		n = res[7];
		v = (op == BBX_OP_CMP || op == BBX_OP_CMPC || op == BBX_OP_CPI)
			? flags_out[`BBX_FLG_V] : (n ^ c_out);
		flags_out[`BBX_FLG_C] = c_out;
		flags_out[`BBX_FLG_N] = n;
		flags_out[`BBX_FLG_V] = v;
		flags_out[`BBX_FLG_S] = n ^ v;
		if (op == BBX_OP_CMPC) begin
			flags_out[`BBX_FLG_Z] = (res == 8'h00) & flags_in[`BBX_FLG_Z];
		end else begin
			flags_out[`BBX_FLG_Z] = (res == 8'h00);
		end
	end

endmodule : bbx_shift
`default_nettype wire

// File: verilog/bbx_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbx_defs.svh"

// Overview of operation
// - Pointer jump: PC from Z, two cycles
// - Relative call: push, PC plus offset plus one
// - Pointer call: push, PC from Z, three cycles
// - Direct call: push, absolute target, four cycles
// - Compare registers, skip next when equal
// - Compare immediate sets Z N V S C H only
// - Skip when register bit is zero
// - Skip when register bit is one
// - Skip when I/O bit reads zero
// - Skip when I/O bit reads one
// - Branch when chosen flag is one
// - Branch when chosen flag is zero
// - Branch when N xor V is zero
// - Branch when N xor V is one
// - Branch on interrupt enable set or clear
// - Set or clear one I/O bit, two cycles
// - Rotate left through carry, update flags
// - Rotate right through carry, update flags
// - Arithmetic shift right keeps bit seven
// - Move bit to T, T to bit
// - Interrupt enable set or clear, one cycle
// - Each flag instruction sets or clears one flag
module bbx_exec
	import bbx_pkg::*;
#(
	parameter int PC_W  = `BBX_PC_W,
	parameter int OFF_W = `BBX_OFF_W
) (
	// Clock and reset
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	// Instruction issue
	input  wire logic            start,
	input  wire bbx_op_t         op,
	input  wire logic [2:0]      bit_sel,
	input  wire logic [2:0]      flag_sel,
	input  wire logic            next_two_word,
	output var  logic            ready,
	output var  logic            done,
	// Operands
	input  wire logic [7:0]      rd_val,
	input  wire logic [7:0]      rr_val,
	input  wire logic [7:0]      imm_val,
	input  wire logic [OFF_W-1:0] rel_off,
	input  wire logic [PC_W-1:0] abs_target,
	// Program counter and pointer
	input  wire logic [PC_W-1:0] pc_cur,
	input  wire logic [PC_W-1:0] z_ptr,
	output var  logic            pc_wr,
	output var  logic [PC_W-1:0] pc_new,
	// Stack
	output var  logic            stack_push,
	output var  logic [PC_W-1:0] stack_wdata,
	output var  logic            stack_pop,
	input  wire logic [PC_W-1:0] stack_rdata,
	// I/O space
	input  wire logic [7:0]      io_rdata,
	output var  logic            io_wr,
	output var  logic [7:0]      io_wdata,
	// Register file write back
	output var  logic            reg_wr,
	output var  logic [7:0]      reg_wdata,
	// Status flags
	input  wire logic            flags_ld,
	input  wire logic [7:0]      flags_in,
	output var  logic [7:0]      flags
);

	localparam bbx_regs_t RST = '{
		st:        BBX_ST_IDLE,
		cnt:       2'h0,
		ready:     1'b1,
		flags:     `BBX_FLAGS_RST,
		p_flags:   `BBX_FLAGS_RST,
		default:   '0
	};

	initial begin
		if (PC_W != `BBX_PC_W || OFF_W < 2 || OFF_W > PC_W) begin
			$error("bbx_exec: unsupported PC_W or OFF_W");
		end
	end

	bbx_regs_t s_q;
	bbx_regs_t s_d;

	logic            take;
	logic [7:0]      sh_res;
	logic [7:0]      sh_flags;
	logic [7:0]      sh_b;
	logic [2:0]      cyc;
	logic            fin;
	logic            own_fl;
	logic [PC_W-1:0] pc_rel;
	logic [PC_W-1:0] pc_inc1;
	logic [PC_W-1:0] pc_inc2;
	logic [PC_W-1:0] pc_skip;
	logic [7:0]      bit_mask;

	assign sh_b = (op == BBX_OP_CPI) ? imm_val : rr_val;

	bbx_cond u_cond (
		.op       (op),
		.bit_sel  (bit_sel),
		.flag_sel (flag_sel),
		.rd_val   (rd_val),
		.rr_val   (rr_val),
		.io_rdata (io_rdata),
		.flags    (s_q.flags),
		.take     (take)
	);

	bbx_shift u_shift (
		.op        (op),
		.a         (rd_val),
		.b         (sh_b),
		.flags_in  (s_q.flags),
		.res       (sh_res),
		.flags_out (sh_flags)
	);

	// Program counter candidates
	always_comb begin
		pc_inc1 = pc_cur + PC_W'(`BBX_STEP_ONE);
		pc_inc2 = pc_cur + PC_W'(`BBX_STEP_TWO);
		pc_rel  = pc_inc1 + PC_W'($signed(rel_off));
		pc_skip = next_two_word ? pc_cur + PC_W'(`BBX_STEP_THREE)
			: pc_inc2;
		bit_mask = 8'h01 << bit_sel;
	end

	// A one-cycle op completes on its taking edge; a longer one waits in
	// the run state and counts down to completion
	always_comb begin
		s_d       = s_q;
		s_d.done  = 1'b0;
		s_d.pc_wr = 1'b0;
		s_d.push  = 1'b0;
		s_d.pop   = 1'b0;
		s_d.io_wr = 1'b0;
		s_d.reg_wr = 1'b0;
		cyc       = `BBX_CYC_ONE;
		fin       = 1'b0;
		own_fl    = 1'b0;
		case (s_q.st)
			BBX_ST_IDLE: begin
				if (start) begin
					// Drop whatever the previous instruction left pending
					s_d.p_pc_wr  = 1'b0;
					s_d.p_push   = 1'b0;
					s_d.p_io_wr  = 1'b0;
					s_d.p_reg_wr = 1'b0;
					s_d.p_ret    = 1'b0;
					s_d.p_interrupt_exit   = 1'b0;
					s_d.p_flags  = s_q.flags;
					s_d.push_data = pc_inc1;
					s_d.io_wdata  = io_rdata;
					s_d.reg_wdata = rd_val;
					case (op)
						BBX_OP_JMP_REL: begin
							cyc         = `BBX_CYC_JMP_REL;
							s_d.p_pc_wr = 1'b1;
							s_d.pc_new  = pc_rel;
						end
						BBX_OP_JMP_Z: begin
							cyc         = `BBX_CYC_JMP_Z;
							s_d.p_pc_wr = 1'b1;
							s_d.pc_new  = z_ptr;
						end
						BBX_OP_JMP_ABS: begin
							cyc         = `BBX_CYC_JMP_ABS;
							s_d.p_pc_wr = 1'b1;
							s_d.pc_new  = abs_target;
						end
						BBX_OP_CAL_REL: begin
							cyc         = `BBX_CYC_CAL_REL;
							s_d.p_pc_wr = 1'b1;
							s_d.p_push  = 1'b1;
							s_d.pc_new  = pc_rel;
						end
						BBX_OP_CAL_Z: begin
							cyc         = `BBX_CYC_CAL_Z;
							s_d.p_pc_wr = 1'b1;
							s_d.p_push  = 1'b1;
							s_d.pc_new  = z_ptr;
						end
						BBX_OP_CAL_ABS: begin
							// Two-word instruction: return past both words
							cyc           = `BBX_CYC_CAL_ABS;
							s_d.p_pc_wr   = 1'b1;
							s_d.p_push    = 1'b1;
							s_d.pc_new    = abs_target;
							s_d.push_data = pc_inc2;
						end
						BBX_OP_RET, BBX_OP_INTERRUPT_EXIT: begin
							cyc         = `BBX_CYC_RET;
							s_d.p_pc_wr = 1'b1;
							s_d.p_ret   = 1'b1;
							s_d.p_interrupt_exit  = (op == BBX_OP_INTERRUPT_EXIT);
							s_d.pop     = 1'b1;
						end
						BBX_OP_COMPARE_SKIP_EQUAL, BBX_OP_SK_RBC, BBX_OP_SK_RBS,
						BBX_OP_SK_IOC, BBX_OP_SK_IOS: begin
							s_d.p_pc_wr = 1'b1;
							if (take) begin
								cyc = next_two_word ? `BBX_CYC_SKIP2
									: `BBX_CYC_SKIP1;
								s_d.pc_new = pc_skip;
							end else begin
								s_d.pc_new = pc_inc1;
							end
						end
						BBX_OP_BR_SET, BBX_OP_BR_CLR,
						BBX_OP_BR_GE, BBX_OP_BR_LT: begin
							s_d.p_pc_wr = 1'b1;
							if (take) begin
								cyc        = `BBX_CYC_BR_TAKE;
								s_d.pc_new = pc_rel;
							end else begin
								s_d.pc_new = pc_inc1;
							end
						end
						BBX_OP_CMP, BBX_OP_CMPC, BBX_OP_CPI: begin
							s_d.p_flags = sh_flags;
							own_fl      = 1'b1;
						end
						BBX_OP_IO_SET: begin
							cyc          = `BBX_CYC_IO_BIT;
							s_d.p_io_wr  = 1'b1;
							s_d.io_wdata = io_rdata | bit_mask;
						end
						BBX_OP_IO_CLR: begin
							cyc          = `BBX_CYC_IO_BIT;
							s_d.p_io_wr  = 1'b1;
							s_d.io_wdata = io_rdata & ~bit_mask;
						end
						BBX_OP_ROL, BBX_OP_ROR, BBX_OP_ASR,
						BBX_OP_LSL, BBX_OP_LSR: begin
							s_d.p_reg_wr  = 1'b1;
							s_d.reg_wdata = sh_res;
							s_d.p_flags   = sh_flags;
							own_fl        = 1'b1;
						end
						BBX_OP_BST: begin
							s_d.p_flags[`BBX_FLG_T] = rd_val[bit_sel];
							own_fl = 1'b1;
						end
						BBX_OP_BLD: begin
							s_d.p_reg_wr = 1'b1;
							s_d.reg_wdata = s_q.flags[`BBX_FLG_T]
								? (rd_val | bit_mask) : (rd_val & ~bit_mask);
						end
						BBX_OP_FLG_SET: begin
							s_d.p_flags[flag_sel] = 1'b1;
							own_fl = 1'b1;
						end
						BBX_OP_FLG_CLR: begin
							s_d.p_flags[flag_sel] = 1'b0;
							own_fl = 1'b1;
						end
						default: begin
							cyc = `BBX_CYC_ONE;
						end
					endcase
					if (cyc == `BBX_CYC_ONE) begin
						fin = 1'b1;
					end else begin
						s_d.st  = BBX_ST_RUN;
						s_d.cnt = 2'(cyc - `BBX_CYC_RUN_ADJ);
					end
				end
			end
			BBX_ST_RUN: begin
				if (s_q.cnt == 2'h0) begin
					fin = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
			end
			default: begin
				s_d.st = BBX_ST_IDLE;
			end
		endcase
		if (fin) begin
			s_d.st     = BBX_ST_IDLE;
			s_d.done   = 1'b1;
			s_d.pc_wr  = s_d.p_pc_wr;
			s_d.push   = s_d.p_push;
			s_d.io_wr  = s_d.p_io_wr;
			s_d.reg_wr = s_d.p_reg_wr;
			if (s_d.p_ret) begin
				s_d.pc_new = stack_rdata;
			end
		end
		// Own flag write wins over an outside load in the same cycle;
		// ops that leave the flags alone let that load through
		if (fin && own_fl) begin
			s_d.flags = s_d.p_flags;
		end else if (flags_ld) begin
			s_d.flags = flags_in;
		end
		if (fin && s_d.p_interrupt_exit) begin
			s_d.flags[`BBX_FLG_I] = 1'b1;
		end
		s_d.ready = (s_d.st == BBX_ST_IDLE);
	end

	// Synchronous reset returns every field to idle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign ready       = s_q.ready;
	assign done        = s_q.done;
	assign pc_wr       = s_q.pc_wr;
	assign pc_new      = s_q.pc_new;
	assign stack_push  = s_q.push;
	assign stack_wdata = s_q.push_data;
	assign stack_pop   = s_q.pop;
	assign io_wr       = s_q.io_wr;
	assign io_wdata    = s_q.io_wdata;
	assign reg_wr      = s_q.reg_wr;
	assign reg_wdata   = s_q.reg_wdata;
	assign flags       = s_q.flags;

endmodule : bbx_exec
`default_nettype wire

// File: bench/bbx_exec_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbx_defs.svh"

module bbx_exec_chk
	import bbx_pkg::*;
#(
	parameter int PC_W  = 16,
	parameter int OFF_W = 12
) (
	// Clock and reset
	input wire logic            clk_sys,
	input wire logic            resetn,
	// Issue
	input wire logic            start,
	input wire bbx_op_t         op,
	input wire logic [2:0]      bit_sel,
	input wire logic [2:0]      flag_sel,
	input wire logic            ready,
	input wire logic            done,
	// Operands
	input wire logic [7:0]      rd_val,
	input wire logic [7:0]      imm_val,
	input wire logic [OFF_W-1:0] rel_off,
	input wire logic [PC_W-1:0] abs_target,
	input wire logic [PC_W-1:0] pc_cur,
	input wire logic [PC_W-1:0] z_ptr,
	// Results
	input wire logic            pc_wr,
	input wire logic [PC_W-1:0] pc_new,
	input wire logic            stack_push,
	input wire logic [PC_W-1:0] stack_wdata,
	input wire logic            stack_pop,
	input wire logic [7:0]      io_rdata,
	input wire logic            io_wr,
	input wire logic [7:0]      io_wdata,
	input wire logic            reg_wr,
	input wire logic [7:0]      reg_wdata,
	input wire logic [7:0]      flags
);
	logic            take;
	logic [PC_W-1:0] rtgt;
	logic [7:0]      rol_exp;

	assign take = start && ready;
	assign rtgt = pc_cur + {{(PC_W-OFF_W){rel_off[OFF_W-1]}}, rel_off} + 1'b1;
	assign rol_exp = {rd_val[6:0], flags[`BBX_FLG_C]};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_jz;
		take && op == BBX_OP_JMP_Z;
	endsequence
	sequence s_ret;
		take && (op == BBX_OP_RET || op == BBX_OP_INTERRUPT_EXIT);
	endsequence

	a_ptr_jump: assert property (
		s_jz |=> !ready ##1 (done && pc_wr && pc_new == $past(z_ptr, 2)))
		else $error("Pointer jump wrong");
	a_ptr_call: assert property (
		take && op == BBX_OP_CAL_Z |-> ##3 (done && stack_push &&
		pc_new == $past(z_ptr, 3) && stack_wdata == $past(pc_cur, 3) + 1'b1))
		else $error("Pointer call wrong");
	a_abs_call: assert property (
		take && op == BBX_OP_CAL_ABS |-> ##4 (done && stack_push &&
		pc_new == $past(abs_target, 4) && stack_wdata == $past(pc_cur, 4) + 2'h2))
		else $error("Direct call wrong");
	a_ret_pop: assert property (
		s_ret |=> stack_pop ##1 (!stack_pop && !done) ##2 (done && pc_wr))
		else $error("Return sequence wrong");
	a_interrupt_exit_irq: assert property (
		take && op == BBX_OP_INTERRUPT_EXIT |-> ##4 flags[`BBX_FLG_I])
		else $error("Interrupt return left enable clear");
	a_io_set: assert property (
		take && op == BBX_OP_IO_SET |-> ##2 (done && io_wr &&
		io_wdata == ($past(io_rdata, 2) | (8'h01 << $past(bit_sel, 2)))))
		else $error("I/O bit set wrong");
	a_cmp_imm: assert property (
		take && op == BBX_OP_CPI |=> (done && !reg_wr &&
		flags[`BBX_FLG_Z] == ($past(rd_val) == $past(imm_val)) &&
		flags[`BBX_FLG_C] == ($past(rd_val) < $past(imm_val))))
		else $error("Compare immediate wrong");
	a_branch_lt: assert property (
		take && op == BBX_OP_BR_LT && (flags[`BBX_FLG_N] ^ flags[`BBX_FLG_V])
		|=> !done ##1 (done && pc_new == $past(rtgt, 2)))
		else $error("Signed less branch wrong");
	a_ge_untaken: assert property (
		take && op == BBX_OP_BR_GE && (flags[`BBX_FLG_N] ^ flags[`BBX_FLG_V])
		|=> (done && pc_new == $past(pc_cur) + 1'b1))
		else $error("Signed ge branch wrong");
	a_flag_set: assert property (
		take && op == BBX_OP_FLG_SET
		|=> flags == ($past(flags) | (8'h01 << $past(flag_sel))))
		else $error("Flag set wrong");
	a_rot_left: assert property (
		take && op == BBX_OP_ROL |=> (reg_wdata == $past(rol_exp) &&
		flags[`BBX_FLG_C] == $past(rd_val[7])))
		else $error("Rotate left wrong");
endmodule : bbx_exec_chk

bind bbx_exec bbx_exec_chk #(.PC_W(PC_W), .OFF_W(OFF_W)) i_chk (
	.clk_sys, .resetn, .start, .op, .bit_sel, .flag_sel, .ready, .done,
	.rd_val, .imm_val, .rel_off, .abs_target, .pc_cur, .z_ptr, .pc_wr,
	.pc_new, .stack_push, .stack_wdata, .stack_pop, .io_rdata, .io_wr,
	.io_wdata, .reg_wr, .reg_wdata, .flags
);

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb
	import bbx_pkg::*;
;
	logic        clk_sys = 1'b0, resetn = 1'b0, start = 1'b0;
	logic        next_two_word = 1'b0, flags_ld = 1'b0;
	bbx_op_t     op = BBX_OP_NONE;
	logic [2:0]  bit_sel = 3'h0, flag_sel = 3'h0;
	logic [7:0]  rd_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00;
	logic [7:0]  io_rdata = 8'h00, flags_in = 8'h00;
	logic [11:0] rel_off = 12'h000;
	logic [15:0] abs_target = 16'h0000, pc_cur = 16'h0100;
	logic [15:0] z_ptr = 16'h1234, stack_rdata = 16'h0000;
	logic [15:0] pc_new, stack_wdata;
	logic        ready, done, pc_wr, stack_push, stack_pop, io_wr, reg_wr;
	logic [7:0]  io_wdata, reg_wdata, flags;
	int          mismatches = 0, tests_run = 0;
	bbx_op_t     sk [4] = '{BBX_OP_SK_RBC, BBX_OP_SK_RBS,
		BBX_OP_SK_IOC, BBX_OP_SK_IOS};

	always #2.5 clk_sys = ~clk_sys;

	bbx_exec i_dut (
		.clk_sys, .resetn, .start, .op, .bit_sel, .flag_sel, .next_two_word,
		.ready, .done, .rd_val, .rr_val, .imm_val, .rel_off, .abs_target,
		.pc_cur, .z_ptr, .pc_wr, .pc_new, .stack_push, .stack_wdata,
		.stack_pop, .stack_rdata, .io_rdata, .io_wr, .io_wdata, .reg_wr,
		.reg_wdata, .flags_ld, .flags_in, .flags
	);

	task report_and_stop();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Issue one instruction and count cycles until done
	task ex(input bbx_op_t o, input int n);
		int c;
		@(negedge clk_sys);
		op = o;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		c = 1;
		while (done !== 1'b1 && c < 8) begin
			@(negedge clk_sys);
			c++;
		end
		if (done !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		chk(16'(c), 16'(n));
	endtask : ex

	task fl(input logic [7:0] v);
		@(negedge clk_sys);
		flags_ld = 1'b1;
		flags_in = v;
		@(negedge clk_sys);
		flags_ld = 1'b0;
	endtask : fl

	initial begin
		logic       b;
		logic [7:0] pat;
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		ex(BBX_OP_JMP_Z, 2);
		chk(pc_new, 16'h1234);
		rel_off = 12'h010;
		ex(BBX_OP_CAL_REL, 3);
		chk(pc_new, 16'h0111);
		chk(stack_wdata, 16'h0101);
		ex(BBX_OP_CAL_Z, 3);
		chk(pc_new, 16'h1234);
		chk(stack_wdata, 16'h0101);
		abs_target = 16'h4000;
		ex(BBX_OP_CAL_ABS, 4);
		chk(pc_new, 16'h4000);
		chk(stack_wdata, 16'h0102);
		stack_rdata = 16'h0abc;
		ex(BBX_OP_RET, 4);
		chk(pc_new, 16'h0abc);
		ex(BBX_OP_INTERRUPT_EXIT, 4);
		chk({8'h00, flags}, 16'h0080);
		flag_sel = 3'h7;
		ex(BBX_OP_FLG_CLR, 1);
		chk({8'h00, flags}, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			flag_sel = 3'(i);
			ex(BBX_OP_FLG_SET, 1);
			chk({8'h00, flags}, {8'h00, 8'hff >> (7 - i)});
		end
		for (int i = 0; i < 8; i++) begin
			flag_sel = 3'(i);
			ex(BBX_OP_FLG_CLR, 1);
			chk({8'h00, flags}, {8'h00, 8'hfe << i});
		end
		// Target of taken branches is 0x0100 - 16 + 1
		pat = 8'ha5;
		fl(pat);
		rel_off = 12'hff0;
		for (int i = 0; i < 8; i++) begin
			b = pat[i];
			flag_sel = 3'(i);
			ex(BBX_OP_BR_SET, b ? 2 : 1);
			chk(pc_new, b ? 16'h00f1 : 16'h0101);
			ex(BBX_OP_BR_CLR, b ? 1 : 2);
			chk(pc_new, b ? 16'h0101 : 16'h00f1);
		end
		ex(BBX_OP_BR_LT, 2);
		chk(pc_new, 16'h00f1);
		ex(BBX_OP_BR_GE, 1);
		chk(pc_new, 16'h0101);
		fl(8'h0c);
		ex(BBX_OP_BR_GE, 2);
		chk(pc_new, 16'h00f1);
		ex(BBX_OP_BR_LT, 1);
		chk(pc_new, 16'h0101);
		rd_val = 8'h33;
		rr_val = 8'h33;
		ex(BBX_OP_COMPARE_SKIP_EQUAL, 2);
		chk(pc_new, 16'h0102);
		next_two_word = 1'b1;
		ex(BBX_OP_COMPARE_SKIP_EQUAL, 3);
		chk(pc_new, 16'h0103);
		rr_val = 8'h34;
		ex(BBX_OP_COMPARE_SKIP_EQUAL, 1);
		chk(pc_new, 16'h0101);
		next_two_word = 1'b0;
		rd_val = 8'h20;
		io_rdata = 8'h20;
		for (int k = 0; k < 8; k++) begin
			bit_sel = (k < 4) ? 3'h5 : 3'h4;
			b = (k[0] == (k < 4));
			ex(sk[k % 4], 1 + b);
			chk(pc_new, 16'h0101 + b);
		end
		io_rdata = 8'h5a;
		bit_sel = 3'h0;
		ex(BBX_OP_IO_SET, 2);
		chk({8'h00, io_wdata}, 16'h005b);
		bit_sel = 3'h1;
		ex(BBX_OP_IO_CLR, 2);
		chk({8'h00, io_wdata}, 16'h0058);
		chk({8'h00, flags}, 16'h000c);
		// Outside flag load lands while a pointer jump is running
		@(negedge clk_sys);
		op = BBX_OP_JMP_Z;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		flags_ld = 1'b1;
		flags_in = 8'h3c;
		@(negedge clk_sys);
		flags_ld = 1'b0;
		chk({7'h00, done, flags}, 16'h013c);
		fl(8'h00);
		rd_val = 8'h80;
		ex(BBX_OP_ROL, 1);
		chk({reg_wdata, flags}, 16'h001b);
		rd_val = 8'h02;
		ex(BBX_OP_ROR, 1);
		chk({reg_wdata, flags}, 16'h810c);
		rd_val = 8'h81;
		ex(BBX_OP_ASR, 1);
		chk({reg_wdata, flags}, 16'hc015);
		rd_val = 8'h10;
		imm_val = 8'h10;
		ex(BBX_OP_CPI, 1);
		chk({13'h0000, reg_wr, flags[1:0]}, 16'h0002);
		rd_val = 8'h0f;
		ex(BBX_OP_CPI, 1);
		chk({14'h0000, flags[1:0]}, 16'h0001);
		rd_val = 8'h20;
		bit_sel = 3'h5;
		ex(BBX_OP_BST, 1);
		chk({15'h0000, flags[6]}, 16'h0001);
		rd_val = 8'h00;
		bit_sel = 3'h3;
		ex(BBX_OP_BLD, 1);
		chk({8'h00, reg_wdata}, 16'h0008);
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
